// ==== hw/sas_top.sv ====
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "sas_params.svh"

module sas_top #(
    parameter int TICK_CYC = `SAS_TICK_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire sas_pkg::sas_wb_req_t wb_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 smoke_cmp_i,
    input  wire logic                 lowbat_cmp_i,
    input  wire logic                 osc_timing_input_i,
    input  wire logic                 io_i,
    output var sas_pkg::sas_drv_t     drv_o
);

    // *********************************
    // timing constants in ticks
    // *********************************

    localparam logic [15:0] T_STB   = 16'(`SAS_STROBE_US / `SAS_TICK_US);
    localparam logic [15:0] T_PSB   = 16'(`SAS_PER_SB_US / `SAS_TICK_US);
    localparam logic [15:0] T_PAL   = 16'(`SAS_PER_AL_US / `SAS_TICK_US);
    localparam logic [15:0] T_HON   = 16'(`SAS_HORN_ON_US / `SAS_TICK_US);
    localparam logic [15:0] T_HOFF  = 16'(`SAS_HORN_OFF_US / `SAS_TICK_US);
    localparam logic [15:0] T_IODLY = 16'(`SAS_IO_DLY_US / `SAS_TICK_US);
    localparam logic [15:0] T_FILT  = 16'(`SAS_IO_FILT_US / `SAS_TICK_US);
    localparam logic [15:0] T_HLAST = T_HON + T_HOFF - 16'h0001;
    localparam logic [4:0]  SLOT_LAST = 5'(`SAS_LED_PERIODS - 1);
    localparam logic [4:0]  SLOT_CHIRP = 5'(`SAS_CHIRP_SLOT);

    // *********************************
    // state
    // *********************************

    logic [31:0]        div_r;
    logic               tick_r;
    sas_pkg::sas_mode_t mode_r;
    sas_pkg::sas_mode_t mode_nxt;
    logic [15:0]        per_r;
    logic [4:0]         slot_r;
    logic [15:0]        hcnt_r;
    logic [15:0]        flt_r;
    logic [15:0]        ldly_r;
    logic               smoke_r;
    logic               lowbat_r;
    logic               test_r;
    logic               ack_r;
    logic [31:0]        rd_r;
    sas_pkg::sas_drv_t  drv_r;
    sas_pkg::sas_drv_t  drv_nxt;
    sas_pkg::sas_stat_t stat;

    // *********************************
    // tick divider
    // *********************************

    // one tick enable per half millisecond drives every timer
    wire div_end = (div_r == 32'(TICK_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_r  <= 32'(TICK_CYC > 1); // one step on: the tick register costs a cycle
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_end ? 32'h0 : div_r + 32'h1;
            tick_r <= div_end;
        end
    end

    // *********************************
    // oscillator period
    // *********************************

    wire in_stby  = (mode_r == sas_pkg::SAS_STBY);
    wire in_local = (mode_r == sas_pkg::SAS_LOCAL);
    wire in_rem   = (mode_r == sas_pkg::SAS_REMOTE);
    wire in_dump  = (mode_r == sas_pkg::SAS_DUMP);
    wire alarm    = in_local | in_rem;

    wire [15:0] per_last = alarm ? T_PAL - 16'h0001 : T_PSB - 16'h0001;
    // >= so a long standby count wraps at once on entering alarm
    wire per_wrap = tick_r & (per_r >= per_last);
    // the dump period starts fresh so it lasts one full period
    wire per_clr  = in_local & (mode_nxt == sas_pkg::SAS_DUMP);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_r <= 16'h0000;
        end else if (per_clr || per_wrap) begin
            per_r <= 16'h0000;
        end else if (tick_r) begin
            per_r <= per_r + 16'h0001;
        end
    end

    // 24 periods per LED slot cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            slot_r <= 5'h00;
        end else if (per_wrap) begin
            slot_r <= (slot_r == SLOT_LAST) ? 5'h00 : slot_r + 5'h01;
        end
    end

    wire in_stb  = (per_r < T_STB);
    wire stb_end = tick_r & (per_r == T_STB - 16'h0001);
    wire led_slot   = (slot_r == 5'h00);
    wire chirp_slot = (slot_r == SLOT_CHIRP);

    // *********************************
    // horn cadence
    // *********************************

    always_ff @(posedge clk_i) begin
        if (rst_i || !alarm) begin
            hcnt_r <= 16'h0000;
        end else if (tick_r) begin
            hcnt_r <= (hcnt_r == T_HLAST) ? 16'h0000 : hcnt_r + 16'h0001;
        end
    end

    wire horn_al  = alarm & (hcnt_r < T_HON);
    wire hcyc_end = tick_r & alarm & (hcnt_r == T_HLAST);

    wire chirp = in_stby & lowbat_r & chirp_slot & in_stb;

    // *********************************
    // comparator latches
    // *********************************

    // battery is only trusted with the LED load on, in standby
    wire lb_test = in_stby & led_slot;
    wire smp_ok  = !lb_test & !(in_stby & lowbat_r & chirp_slot) & !horn_al;

    // latched at end of strobe, when the analog side has settled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smoke_r  <= 1'b0;
            lowbat_r <= 1'b0;
        end else if (stb_end) begin
            if (smp_ok) begin
                smoke_r <= smoke_cmp_i;
            end
            if (lb_test) begin
                lowbat_r <= lowbat_cmp_i;
            end
        end
    end

    // software test acts as smoke, so leaving it also dumps
    wire smoke_det = smoke_r | test_r;

    // *********************************
    // interconnect filter and delay
    // *********************************

    always_ff @(posedge clk_i) begin
        if (rst_i || in_local || !io_i) begin
            flt_r <= 16'h0000;
        end else if (tick_r && (flt_r < T_FILT)) begin
            flt_r <= flt_r + 16'h0001;
        end
    end

    wire io_valid = (flt_r >= T_FILT);

    always_ff @(posedge clk_i) begin
        if (rst_i || !in_local) begin
            ldly_r <= 16'h0000;
        end else if (tick_r && (ldly_r < T_IODLY)) begin
            ldly_r <= ldly_r + 16'h0001;
        end
    end

    wire io_drive = in_local & (ldly_r >= T_IODLY);

    // *********************************
    // sequencing
    // *********************************

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            sas_pkg::SAS_STBY: begin
                if (smoke_det) begin
                    mode_nxt = sas_pkg::SAS_LOCAL;
                end else if (io_valid) begin
                    mode_nxt = sas_pkg::SAS_REMOTE;
                end
            end
            sas_pkg::SAS_LOCAL: begin
                if (hcyc_end && !smoke_det) begin
                    mode_nxt = sas_pkg::SAS_DUMP;
                end
            end
            sas_pkg::SAS_REMOTE: begin
                if (smoke_det) begin
                    mode_nxt = sas_pkg::SAS_LOCAL;
                end else if (hcyc_end && !io_valid) begin
                    mode_nxt = sas_pkg::SAS_STBY;
                end
            end
            sas_pkg::SAS_DUMP: begin
                if (smoke_det) begin
                    mode_nxt = sas_pkg::SAS_LOCAL;
                end else if (per_wrap) begin
                    mode_nxt = sas_pkg::SAS_STBY;
                end
            end
            default: begin
                mode_nxt = sas_pkg::SAS_STBY;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_r <= sas_pkg::SAS_STBY;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // *********************************
    // pin drivers
    // *********************************

    always_comb begin
        drv_nxt.horn   = horn_al | chirp;
        drv_nxt.led    = in_stb & led_slot & !in_rem;
        drv_nxt.trim   = in_stb & led_slot & !in_rem;
        drv_nxt.strobe = in_stb | !osc_timing_input_i;
        drv_nxt.io_o   = io_drive;
        drv_nxt.io_oe  = io_drive | in_dump;
        drv_nxt.dump   = in_dump;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drv_r <= '0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    assign drv_o = drv_r;

    // *********************************
    // wishbone slave
    // *********************************

    // one wait state: ack follows the request by one edge
    wire wb_req   = wb_i.cyc & wb_i.stb & !ack_r;
    wire ctrl_hit = (wb_i.adr == `SAS_ADR_CTRL);
    wire stat_hit = (wb_i.adr == `SAS_ADR_STAT);
    wire ctrl_wr  = wb_req & wb_i.we & ctrl_hit & wb_i.sel[0];

    assign stat.rsvd     = 24'h000000;
    assign stat.io_drive = io_drive;
    assign stat.io_valid = io_valid;
    assign stat.lowbat   = lowbat_r;
    assign stat.smoke    = smoke_r;
    assign stat.mode     = mode_r;

    // unmapped addresses still ack, reading zero
    wire [31:0] rd_nxt = ctrl_hit ? {31'h0, test_r} : (stat_hit ? stat : 32'h0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rd_r   <= 32'h0;
            test_r <= `SAS_CTRL_RST;
        end else begin
            ack_r <= wb_req;
            rd_r  <= wb_req ? rd_nxt : 32'h0;
            if (ctrl_wr) begin
                test_r <= wb_i.dat[`SAS_CTRL_TEST];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;

    // *********************************
    // assertions
    // *********************************

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    property p_strobe_forced;
        !osc_timing_input_i |=> drv_r.strobe;
    endproperty
    a_strobe_forced: assert property (p_strobe_forced)
        else $error("strobe not forced by low timing input");

    property p_io_high_local;
        drv_r.io_o |-> drv_r.io_oe && $past(in_local) && $past(ldly_r) >= T_IODLY;
    endproperty
    a_io_high_local: assert property (p_io_high_local)
        else $error("line driven high without 3 s local alarm");

    property p_no_led_remote;
        in_rem |=> !drv_r.led && !drv_r.trim;
    endproperty
    a_no_led_remote: assert property (p_no_led_remote)
        else $error("LED flashed in remote alarm");

    property p_no_dump_remote;
        in_rem |=> !in_dump;
    endproperty
    a_no_dump_remote: assert property (p_no_dump_remote)
        else $error("dump after remote alarm");

    property p_horn_cause;
        drv_r.horn |-> $past(alarm) || ($past(in_stby) && $past(lowbat_r));
    endproperty
    a_horn_cause: assert property (p_horn_cause)
        else $error("horn without alarm or low battery");

    property p_trim_led;
        drv_r.trim == drv_r.led;
    endproperty
    a_trim_led: assert property (p_trim_led)
        else $error("trim switch outside LED pulse");

    property p_local_exit;
        in_local ##1 !in_local && !in_rem |-> $past(hcyc_end);
    endproperty
    a_local_exit: assert property (p_local_exit)
        else $error("local alarm left mid horn cycle");

    property p_smoke_hold;
        $changed(smoke_r) |-> !$past(horn_al) && !$past(lb_test);
    endproperty
    a_smoke_hold: assert property (p_smoke_hold)
        else $error("smoke sampled while blocked");

    property p_remote_filt;
        in_stby ##1 in_rem |-> $past(flt_r) >= T_FILT;
    endproperty
    a_remote_filt: assert property (p_remote_filt)
        else $error("remote alarm before filter time");

    property p_dump_sink;
        in_dump |=> drv_r.io_oe && !drv_r.io_o;
    endproperty
    a_dump_sink: assert property (p_dump_sink)
        else $error("sink off during dump");

    property p_wb_ack;
        wb_req |=> ack_r ##1 !ack_r;
    endproperty
    a_wb_ack: assert property (p_wb_ack)
        else $error("bus ack not a single cycle");

    c_local:  cover property (in_stby ##1 in_local);
    c_remote: cover property (in_stby ##1 in_rem);
    c_dump:   cover property (in_dump ##1 in_stby);
    c_chirp:  cover property ($rose(chirp));

endmodule

`default_nettype wire

// ==== hw/sas_params.svh ====
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

`define SAS_CLK_NS       10
`define SAS_TICK_US      500
`define SAS_TICK_CYC     (`SAS_TICK_US * 1000 / `SAS_CLK_NS)
`define SAS_STROBE_US    10500
`define SAS_PER_SB_US    1670000
`define SAS_PER_AL_US    41500
`define SAS_HORN_ON_US   166000
`define SAS_HORN_OFF_US  83000
`define SAS_IO_DLY_US    3000000
`define SAS_IO_FILT_US   500000
`define SAS_LED_PERIODS  24
`define SAS_CHIRP_SLOT   12
`define SAS_ADR_CTRL     8'h00
`define SAS_ADR_STAT     8'h04
`define SAS_CTRL_TEST    0
`define SAS_CTRL_RST     1'h0

`endif

// ==== hw/sas_pkg.sv ====
package sas_pkg;

    typedef enum logic [3:0] {
        SAS_STBY   = 4'h1,
        SAS_LOCAL  = 4'h2,
        SAS_REMOTE = 4'h4,
        SAS_DUMP   = 4'h8
    } sas_mode_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } sas_wb_req_t;

    typedef struct packed {
        logic horn;
        logic led;
        logic trim;
        logic strobe;
        logic io_o;
        logic io_oe;
        logic dump;
    } sas_drv_t;

    typedef struct packed {
        logic [23:0] rsvd;
        logic        io_drive;
        logic        io_valid;
        logic        lowbat;
        logic        smoke;
        logic [3:0]  mode;
    } sas_stat_t;

endpackage

// ==== testbench/sas_peer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// far unit on the shared interconnect line
// ************************************************
module sas_peer #(
    parameter int DLY = 0
) (
    input  wire logic clk_i,
    input  wire logic alarm_i,
    output wire logic line_hi_o
);
    int cnt_r;

    // a slow unit only raises the line DLY cycles into its alarm
    always_ff @(posedge clk_i) begin
        cnt_r <= alarm_i ? cnt_r + 1 : 0;
    end
    assign line_hi_o = alarm_i && (cnt_r >= DLY);
endmodule
`default_nettype wire

// ==== testbench/tb_smoke_alarm_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// self-checking bench, short ticks keep runs small
// ************************************************
module tb_smoke_alarm_sequencer;
    localparam int TK = 4;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    sas_pkg::sas_wb_req_t wb_i = '0;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 smoke_i = 1'b1;
    logic                 lowbat_i = 1'b1;
    logic                 osc_i = 1'b1;
    logic                 peer_on = 1'b0;
    wire logic            peer_hi;
    wire logic            io_w;
    sas_pkg::sas_drv_t    drv_o;
    int                   fail_count = 0;
    int                   tests_run = 0;
    int                   cyc_n = 0;
    int                   n;
    int                   t0;
    logic [31:0]          lfsr = 32'hF647B70E;
    logic [31:0]          rd;
    logic [31:0]          ctrl_m = 32'h0;

    sas_top #(.TICK_CYC(TK)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .smoke_cmp_i(smoke_i),
        .lowbat_cmp_i(lowbat_i), .osc_timing_input_i(osc_i), .io_i(io_w), .drv_o(drv_o));
    sas_peer #(.DLY(3)) peer_u (.clk_i(clk_i), .alarm_i(peer_on), .line_hi_o(peer_hi));

    // line is pulled low unless someone drives it high
    assign io_w = (drv_o.io_oe & drv_o.io_o) | peer_hi;

    always #5 clk_i = ~clk_i;

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string s);
        tests_run++;
        if (act !== exp) begin
            fail_count++;
            $display("Error %0t: %s got %0h want %0h", $time, s, act, exp);
        end
    endtask

    task automatic chk_in(input int act, input int lo, input int hi, input string s);
        tests_run++;
        if (act < lo || act > hi) begin
            fail_count++;
            $display("Error %0t: %s got %0d", $time, s, act);
        end
    endtask

    // wait for drv bit b to equal v, then count cycles it stays so
    task automatic run_len(input int b, input logic v, output int len, input bit wo);
        int k;
        k = 0;
        len = 0;
        while (drv_o[b] !== v && k < 30000) begin
            @(negedge clk_i);
            k++;
        end
        while (!wo && drv_o[b] === v && len < 30000) begin
            @(negedge clk_i);
            len++;
        end
    endtask

    // single classic cycle, held until ack is seen at a rising edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        rd = wb_dat_o;
        wb_i <= '0;
        if (we && a == 8'h00) begin
            ctrl_m = {31'h0, d[0]};
        end
        if (!we && a != 8'h04) begin
            chk(rd, (a == 8'h00) ? ctrl_m : 32'h0, "read data");
        end
    endtask

    task automatic tend(input string s);
        $display("done: %s", s);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // trim switch must track the led pulse every cycle
    always @(negedge clk_i) begin
        chk({31'h0, drv_o.trim}, {31'h0, drv_o.led}, "trim"); // trim follows led
    end

    // hang guard, the sequence needs about 77k cycles
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 110000) begin
            fail_count++;
            $display("Error %0t: timeout", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({25'h0, drv_o}, 32'h0, "reset outputs"); // outputs cleared
        run_len(5, 1'b1, n, 1'b0);
        chk(n, 21 * TK, "led width"); // standby led pulse
        t0 = cyc_n;
        wb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h21, "status slot0"); // smoke skipped in battery test
        run_len(3, 1'b1, n, 1'b1);
        chk(cyc_n - t0, 3319 * TK, "standby gap"); // strobe once per period
        tend("standby");
        // the first burst starts mid tick, so widths come from the second one
        run_len(6, 1'b1, n, 1'b0);
        t0 = cyc_n - n;
        run_len(6, 1'b0, n, 1'b0);
        run_len(6, 1'b1, n, 1'b0);
        chk(n, 332 * TK, "horn on"); // horn on time
        run_len(6, 1'b0, n, 1'b0);
        chk(n, 166 * TK, "horn off"); // horn off time
        run_len(3, 1'b1, n, 1'b0);
        run_len(3, 1'b0, rd, 1'b0);
        chk(n + rd, 83 * TK, "alarm period"); // short period
        run_len(5, 1'b1, n, 1'b0);
        chk(n, 21 * TK, "alarm led"); // led width
        run_len(5, 1'b0, n, 1'b0);
        chk(n + 21 * TK, 24 * 83 * TK, "alarm led rate"); // led every second
        run_len(1, 1'b1, n, 1'b1);
        chk_in(cyc_n - t0, 5999 * TK, 6001 * TK, "io delay"); // drive delay
        chk({31'h0, io_w}, 32'h1, "line high"); // line driven high
        tend("local alarm");
        @(posedge clk_i);
        smoke_i <= 1'b0;
        run_len(0, 1'b1, n, 1'b1);
        chk({30'h0, drv_o.io_oe, drv_o.io_o}, 32'h2, "dump sink"); // line sunk
        run_len(0, 1'b1, n, 1'b0);
        chk(n, 3340 * TK, "dump width"); // one standby period
        tend("dump");
        @(posedge clk_i);
        peer_on <= 1'b1;
        repeat (2000 + rnd() % 1600) @(posedge clk_i);
        peer_on <= 1'b0;
        repeat (4100) @(posedge clk_i);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'hF, 32'h1, "short pulse"); // pulse filtered
        peer_on <= 1'b1;
        t0 = cyc_n;
        run_len(6, 1'b1, n, 1'b1);
        chk_in(cyc_n - t0, 900 * TK, 4400 * TK, "remote delay"); // horn delay
        n = 0;
        repeat (8000) begin
            @(negedge clk_i);
            n += drv_o.led;
        end
        chk(n, 0, "remote led"); // led suppressed
        @(posedge clk_i);
        peer_on <= 1'b0;
        n = 0;
        repeat (3000) begin
            @(negedge clk_i);
            n += drv_o.dump;
        end
        chk(n, 0, "remote dump"); // no dump after remote
        wb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'hF, 32'h1, "remote exit"); // back to standby
        tend("remote alarm");
        wb(1'b1, 8'h00, rnd() | 32'h1);
        wb(1'b0, 8'h00, 32'h0);
        wb(1'b1, 8'h0C, rnd());
        wb(1'b0, 8'h0C, 32'h0);
        wb(1'b0, 8'h04, 32'h0);
        chk(rd & 32'hF, 32'h2, "test mode"); // test acts as smoke
        wb(1'b1, 8'h00, 32'h0);
        run_len(6, 1'b1, n, 1'b0);
        t0 = cyc_n;
        run_len(0, 1'b1, n, 1'b1);
        chk_in(cyc_n - t0, 166 * TK - 2, 166 * TK + 2, "cycle done"); // cycle completes
        // wait out the dump period's own strobe so the forcing is visible
        run_len(3, 1'b0, n, 1'b1);
        @(posedge clk_i);
        osc_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk({31'h0, drv_o.strobe}, 32'h1, "osc low"); // strobe forced
        @(posedge clk_i);
        osc_i <= 1'b1;
        tend("bus and test");
        report_and_stop();
    end
endmodule
`default_nettype wire
